// *** core/leadoff_regs.svh ***
// Purpose: register indices, field positions and reset values of the lead-off, pin, tap and breathing bank
// Assumes: each printed offset is a word index; the APB byte address is four times it
// Notes: definitions only
//
// Functional notes
// - index 0Fh holds one positive-electrode lead-off sense enable per channel.
// - index 10h holds one negative-electrode lead-off sense enable per channel.
// - sense bits 5:4 absent on four channels, bits 7:6 absent below eight.
// - index 11h holds one excitation current direction bit per channel.
// - read-only index 12h shows positive electrode state, 0 on, 1 off.
// - read-only index 13h shows negative electrode state, 0 on, 1 off.
// - index 14h bits 7:4 are pin data, bits 3:0 pin direction.
// - reading pin data returns the live pin level, input or output.
// - writing pin data sets the driven level only for output pins.
// - direction bit 0 makes an output, 1 an input; all reset to input.
// - breathing mode 01 or 11 takes pins two, three and four away.
// - tap bits 4:3 pick even channel 2, 4, 6 or 8; reset 00.
// - tap bits 2:1 pick odd channel 1, 3, 5 or 7; reset 00.
// - tap bit 0 turns the tap buffer off at 0, on at 1.
// - breathing bits 4:2 set phase in 22.5 degree steps; reset code 101.
// - pin four runs shifted from pin three by the selected phase.
// - the phase setting has no effect below the top output data rate.
// - breathing bits 1:0 set mode: 00 none, 01 external, reset 01.
`ifndef LEADOFF_REGS_SVH
`define LEADOFF_REGS_SVH

// ==========================================================================
// word indices
`define IDX_SENSE_POS 6'h0F
`define IDX_SENSE_NEG 6'h10
`define IDX_CUR_DIR 6'h11
`define IDX_STAT_POS 6'h12
`define IDX_STAT_NEG 6'h13
`define IDX_PIN_IO 6'h14
`define IDX_TAP_SEL 6'h15
`define IDX_BREATH 6'h16

// ==========================================================================
// field positions
`define PIN_DATA_HI 7
`define PIN_DATA_LO 4
`define PIN_DIR_HI 3
`define PIN_DIR_LO 0
`define TAP_EVEN_HI 4
`define TAP_EVEN_LO 3
`define TAP_ODD_HI 2
`define TAP_ODD_LO 1
`define TAP_BUF_BIT 0
`define BR_PHASE_HI 4
`define BR_PHASE_LO 2
`define BR_MODE_HI 1
`define BR_MODE_LO 0

// ==========================================================================
// reset values
`define RST_BYTE 8'h00
`define RST_PIN_DIR 4'hF
`define RST_PIN_DATA 4'h0
`define RST_TAP 5'h00
`define RST_BREATH 5'h15

// ==========================================================================
// encodings and counts
`define MODE_NONE 2'h0
`define MODE_EXTERNAL 2'h1
`define MODE_RESERVED 2'h3
`define PHASE_STEPS 5'h10
`define HALF_STEPS 4'h8
`define CHAN_STEP 4'h2
`define ODD_BASE 4'h1
`define EVEN_BASE 4'h2

`endif

// *** core/leadoff_pkg.sv ***
// Purpose: carrier types for the lead-off, pin, tap and breathing bank
// Assumes: APB with 8-bit byte addresses and 32-bit data
// Notes: constants live in leadoff_regs.svh
package leadoff_pkg;

  // ==========================================================================
  // apb request bundle, names as published
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // ==========================================================================
  // decoded tap routing
  typedef struct packed {
    logic [3:0] odd_chan;
    logic [3:0] even_chan;
    logic buffer_on;
  } tap_route_t;

endpackage

// *** core/leadoff_gpio_pace_breathing_control_regs.sv ***
// Purpose: APB register bank for lead-off sensing, aux pins, pulse taps and breathing control
// Assumes: lead-off comparator levels arrive synchronous to CLK
// Notes: zero-wait APB slave; unmapped words read zero with PSLVERR
`timescale 1ns/1ps
`include "leadoff_regs.svh"

module leadoff_gpio_pace_breathing_control_regs #(
  parameter int NUM_CHANNELS = 8,
  parameter int BREATH_DIV = 4
) (
  input wire logic CLK, // core clock, 100 MHz
  input wire logic RESET_N, // synchronous reset, active low
  input wire leadoff_pkg::apb_req_t APB_REQ, // apb request bundle
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped word
  input wire logic [7:0] LEAD_OFF_POS_IN, // positive comparators, 1 = off
  input wire logic [7:0] LEAD_OFF_NEG_IN, // negative comparators, 1 = off
  input wire logic TOP_RATE, // output data rate at its top value
  input wire logic [3:0] PIN_IN, // aux pin levels
  output logic [3:0] PIN_OUT, // aux pin drive values
  output logic [3:0] PIN_OE_N, // aux pin enables, low drives
  output logic [7:0] SENSE_POS_EN, // positive electrode sense enables
  output logic [7:0] SENSE_NEG_EN, // negative electrode sense enables
  output logic [7:0] CURRENT_DIR, // excitation current directions
  output leadoff_pkg::tap_route_t TAP_ROUTE, // pulse tap routing
  output logic [1:0] BREATHING_MODE // breathing circuit mode
);
  import leadoff_pkg::*;

  // ==========================================================================
  // channel mask: bits of missing channels never store and read zero
  localparam logic [7:0] CHAN_MASK = 8'(({8'hFF, 8'h00} >> (16 - NUM_CHANNELS)));

  logic [7:0] sense_pos_reg;
  logic [7:0] sense_neg_reg;
  logic [7:0] cur_dir_reg;
  logic [7:0] stat_pos_reg;
  logic [7:0] stat_neg_reg;
  logic [3:0] pin_data_reg;
  logic [3:0] pin_dir_reg;
  logic [3:0] pin_in_reg;
  logic [4:0] tap_reg;
  logic [4:0] breath_reg;
  logic [31:0] rdata_next;
  logic err_next;
  logic [5:0] index;
  logic aligned;
  logic setup;
  logic wr_acc;
  logic [3:0] pin_data_next;
  logic breathing_control_owns_pins;
  logic [3:0] div_reg;
  logic [3:0] step_reg;
  logic [3:0] shift;
  logic [3:0] lag_step;
  logic wave_a;
  logic wave_b;
  logic [3:0] pin_out_next;
  logic [3:0] pin_oe_n_next;

  // ==========================================================================
  // bus decode
  assign index = APB_REQ.paddr[7:2];
  assign aligned = (APB_REQ.paddr[1:0] == 2'h0);
  assign setup = APB_REQ.psel && !APB_REQ.penable;
  // a write lands only on the edge that samples ready high in the access phase
  assign wr_acc = APB_REQ.psel && APB_REQ.penable && PREADY && APB_REQ.pwrite;

  // read mux, evaluated in the setup cycle and registered for the access phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (!aligned) begin
      err_next = 1'b1;
    end else begin
      unique case (index)
        `IDX_SENSE_POS: rdata_next[7:0] = sense_pos_reg;
        `IDX_SENSE_NEG: rdata_next[7:0] = sense_neg_reg;
        `IDX_CUR_DIR: rdata_next[7:0] = cur_dir_reg;
        `IDX_STAT_POS: rdata_next[7:0] = stat_pos_reg;
        `IDX_STAT_NEG: rdata_next[7:0] = stat_neg_reg;
        `IDX_PIN_IO: rdata_next[7:0] = {pin_in_reg, pin_dir_reg};
        `IDX_TAP_SEL: rdata_next[4:0] = tap_reg;
        `IDX_BREATH: rdata_next[4:0] = breath_reg;
        default: err_next = 1'b1;
      endcase
    end
  end

  // zero-wait answer: ready rises in the first access cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && err_next;
      if (setup) begin
        PRDATA <= APB_REQ.pwrite ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // ==========================================================================
  // lead-off enables and current direction; absent channels stay zero
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sense_pos_reg <= `RST_BYTE;
      sense_neg_reg <= `RST_BYTE;
      cur_dir_reg <= `RST_BYTE;
    end else if (wr_acc && aligned) begin
      if (index == `IDX_SENSE_POS) begin
        sense_pos_reg <= APB_REQ.pwdata[7:0] & CHAN_MASK;
      end
      if (index == `IDX_SENSE_NEG) begin
        sense_neg_reg <= APB_REQ.pwdata[7:0] & CHAN_MASK;
      end
      if (index == `IDX_CUR_DIR) begin
        cur_dir_reg <= APB_REQ.pwdata[7:0] & CHAN_MASK;
      end
    end
  end

  // status follows the comparators only; bus writes never reach it
  // software must mask it with the sense enables itself
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      stat_pos_reg <= `RST_BYTE;
      stat_neg_reg <= `RST_BYTE;
    end else begin
      stat_pos_reg <= LEAD_OFF_POS_IN & CHAN_MASK;
      stat_neg_reg <= LEAD_OFF_NEG_IN & CHAN_MASK;
    end
  end

  // ==========================================================================
  // aux pins: data bits only take a write where the pin is an output
  always_comb begin
    pin_data_next = pin_data_reg;
    for (int i = 0; i < 4; i++) begin
      if (!pin_dir_reg[i]) begin
        pin_data_next[i] = APB_REQ.pwdata[`PIN_DATA_LO + i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pin_dir_reg <= `RST_PIN_DIR;
      pin_data_reg <= `RST_PIN_DATA;
    end else if (wr_acc && aligned && index == `IDX_PIN_IO) begin
      pin_dir_reg <= APB_REQ.pwdata[`PIN_DIR_HI:`PIN_DIR_LO];
      pin_data_reg <= pin_data_next;
    end
  end

  // pin levels are synchronous, one sample stage keeps the read path short
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pin_in_reg <= 4'h0;
    end else begin
      pin_in_reg <= PIN_IN;
    end
  end

  // ==========================================================================
  // tap and breathing controls; upper bits are not stored
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tap_reg <= `RST_TAP;
      breath_reg <= `RST_BREATH;
    end else if (wr_acc && aligned) begin
      if (index == `IDX_TAP_SEL) begin
        tap_reg <= APB_REQ.pwdata[4:0];
      end
      if (index == `IDX_BREATH) begin
        breath_reg <= APB_REQ.pwdata[4:0];
      end
    end
  end

  // ==========================================================================
  // breathing wave: sixteen steps of 22.5 degrees per period
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      div_reg <= 4'h0;
      step_reg <= 4'h0;
    end else if (div_reg == 4'(BREATH_DIV - 1)) begin
      div_reg <= 4'h0;
      step_reg <= step_reg + 4'h1;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // below the top rate the phase field is ignored and a half period is used
  assign shift = TOP_RATE ? 4'({1'b0, breath_reg[`BR_PHASE_HI:`BR_PHASE_LO]} + 4'h1) : `HALF_STEPS;
  assign lag_step = step_reg - shift;
  assign wave_a = (step_reg < `HALF_STEPS);
  assign wave_b = (lag_step < `HALF_STEPS);
  assign breathing_control_owns_pins = breath_reg[`BR_MODE_LO];

  // ==========================================================================
  // pin drive; respiration modes take pins two to four from software
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      if (g == 0) begin : g_free
        assign pin_out_next[g] = pin_data_reg[g];
        assign pin_oe_n_next[g] = pin_dir_reg[g];
      end else if (g == 1) begin : g_idle
        assign pin_out_next[g] = breathing_control_owns_pins ? 1'b0 : pin_data_reg[g];
        assign pin_oe_n_next[g] = breathing_control_owns_pins ? 1'b1 : pin_dir_reg[g];
      end else begin : g_wave
        assign pin_out_next[g] = breathing_control_owns_pins ? ((g == 2) ? wave_a : wave_b) : pin_data_reg[g];
        assign pin_oe_n_next[g] = breathing_control_owns_pins ? 1'b0 : pin_dir_reg[g];
      end
    end
  endgenerate

  // every output leaves from a flop
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PIN_OUT <= 4'h0;
      PIN_OE_N <= 4'hF;
      SENSE_POS_EN <= `RST_BYTE;
      SENSE_NEG_EN <= `RST_BYTE;
      CURRENT_DIR <= `RST_BYTE;
      TAP_ROUTE <= '{odd_chan: `ODD_BASE, even_chan: `EVEN_BASE, buffer_on: 1'b0};
      BREATHING_MODE <= `MODE_EXTERNAL;
    end else begin
      PIN_OUT <= pin_out_next;
      PIN_OE_N <= pin_oe_n_next;
      SENSE_POS_EN <= sense_pos_reg;
      SENSE_NEG_EN <= sense_neg_reg;
      CURRENT_DIR <= cur_dir_reg;
      TAP_ROUTE.odd_chan <= `ODD_BASE + `CHAN_STEP * {2'h0, tap_reg[`TAP_ODD_HI:`TAP_ODD_LO]};
      TAP_ROUTE.even_chan <= `EVEN_BASE + `CHAN_STEP * {2'h0, tap_reg[`TAP_EVEN_HI:`TAP_EVEN_LO]};
      TAP_ROUTE.buffer_on <= tap_reg[`TAP_BUF_BIT];
      BREATHING_MODE <= breath_reg[`BR_MODE_HI:`BR_MODE_LO];
    end
  end

  // ==========================================================================
  // checks
  // an attempt taken at the release edge still sees reset values on the flops, so guards use RESET_N
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence wr_to(logic [5:0] idx);
    wr_acc && aligned && index == idx;
  endsequence

  sense_pos_store_a: assert property (wr_to(`IDX_SENSE_POS) |=> ##1
      SENSE_POS_EN == ($past(APB_REQ.pwdata[7:0], 2) & CHAN_MASK))
    else $error("positive sense enable not stored");

  sense_neg_store_a: assert property (wr_to(`IDX_SENSE_NEG) |=> sense_neg_reg ==
      ($past(APB_REQ.pwdata[7:0]) & CHAN_MASK))
    else $error("negative sense enable not stored");

  absent_chan_zero_a: assert property (((sense_pos_reg | sense_neg_reg) & ~CHAN_MASK) == 8'h00)
    else $error("absent channel bit set");

  cur_dir_store_a: assert property (wr_to(`IDX_CUR_DIR) |=> ##1
      CURRENT_DIR == ($past(APB_REQ.pwdata[7:0], 2) & CHAN_MASK))
    else $error("current direction not stored");

  stat_pos_track_a: assert property (##1 stat_pos_reg == ($past(LEAD_OFF_POS_IN) & CHAN_MASK))
    else $error("positive status does not follow comparators");

  stat_wr_ignore_a: assert property (wr_to(`IDX_STAT_NEG) |=>
      stat_neg_reg == ($past(LEAD_OFF_NEG_IN) & CHAN_MASK))
    else $error("status changed by a write");

  pin_read_live_a: assert property (setup && !APB_REQ.pwrite && aligned && index == `IDX_PIN_IO |=>
      PRDATA[`PIN_DATA_HI:`PIN_DATA_LO] == $past(pin_in_reg))
    else $error("pin read does not show pin levels");

  input_pin_hold_a: assert property (wr_acc && aligned && index == `IDX_PIN_IO && pin_dir_reg[0] |=>
      pin_data_reg[0] == $past(pin_data_reg[0]))
    else $error("write changed an input pin");

  dir_to_enable_a: assert property (##1 !breathing_control_owns_pins && $past(!breathing_control_owns_pins) |->
      PIN_OE_N == $past(pin_dir_reg))
    else $error("pin enable does not follow direction");

  breathing_control_takes_pins_a: assert property (RESET_N && breathing_control_owns_pins |=> PIN_OE_N[1] && !PIN_OE_N[2])
    else $error("breathing mode left pins to software");

  even_tap_map_a: assert property (##1 TAP_ROUTE.even_chan ==
      4'($past(tap_reg[`TAP_EVEN_HI:`TAP_EVEN_LO]) * 2 + 2))
    else $error("even tap channel wrong");

  phase_lag_a: assert property (breathing_control_owns_pins && TOP_RATE |->
      4'(lag_step + {1'b0, breath_reg[`BR_PHASE_HI:`BR_PHASE_LO]} + 4'h1) == step_reg)
    else $error("breathing phase lag wrong");

  slow_rate_half_a: assert property (breathing_control_owns_pins && !TOP_RATE |->
      4'(lag_step + `HALF_STEPS) == step_reg)
    else $error("phase field used below the top rate");

  pin_wave_drive_a: assert property (RESET_N && breathing_control_owns_pins |=>
      PIN_OUT[2] == $past(wave_a) && PIN_OUT[3] == $past(wave_b))
    else $error("breathing wave not on pins three and four");

  // ==========================================================================
  // bus and copy checks; the copies lag their registers by one cycle
  sequence read_setup(logic [5:0] idx);
    setup && !APB_REQ.pwrite && aligned && index == idx;
  endsequence

  apb_zero_wait_a: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("ready not a single cycle after setup");

  unmapped_error_a: assert property (setup && aligned && index > `IDX_BREATH |=> PSLVERR)
    else $error("unmapped word answered without error");

  stat_pos_read_a: assert property (read_setup(`IDX_STAT_POS) |=>
      PREADY && PRDATA[7:0] == $past(stat_pos_reg))
    else $error("positive status read wrong");

  stat_neg_track_a: assert property (##1 stat_neg_reg == ($past(LEAD_OFF_NEG_IN) & CHAN_MASK))
    else $error("negative status does not follow comparators");

  stat_wr_quiet_a: assert property (setup && APB_REQ.pwrite && aligned && index == `IDX_STAT_POS |=>
      PREADY && !PSLVERR)
    else $error("status write answered with error");

  pin_write_output_a: assert property (wr_acc && aligned && index == `IDX_PIN_IO && !pin_dir_reg[1] |=>
      pin_data_reg[1] == $past(APB_REQ.pwdata[`PIN_DATA_LO + 1]))
    else $error("output pin data not written");

  odd_tap_map_a: assert property (##1 TAP_ROUTE.odd_chan ==
      4'($past(tap_reg[`TAP_ODD_HI:`TAP_ODD_LO]) * 2 + 1))
    else $error("odd tap channel wrong");

  tap_buffer_copy_a: assert property (##1 TAP_ROUTE.buffer_on == $past(tap_reg[`TAP_BUF_BIT]))
    else $error("tap buffer enable wrong");

  mode_copy_a: assert property (##1 BREATHING_MODE == $past(breath_reg[`BR_MODE_HI:`BR_MODE_LO]))
    else $error("breathing mode output wrong");

endmodule

// *** dv/test_leadoff_gpio_pace_breathing_control_regs.sv ***
// Purpose: self-checking bench for the lead-off, aux pin, pulse tap and breathing register bank
// Assumes: zero-wait APB slave; byte address is four times the word index
// Notes: six-channel build so that absent sense bits get exercised
`timescale 1ns/1ps
`include "leadoff_regs.svh"

module test_leadoff_gpio_pace_breathing_control_regs;
  import leadoff_pkg::*;
  localparam int DIV = 4;
  localparam logic [7:0] CH_MASK = 8'h3F;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic top_rate = 1'b1;
  logic [7:0] lo_pos = 8'h00, lo_neg = 8'h00, sp, sn, cd;
  logic [3:0] ext_lvl = 4'h0, pin_in, pin_out, pin_oe_n;
  logic [1:0] br_mode;
  tap_route_t tap_route;
  int m[8] = '{0, 0, 0, 0, 0, 'h0F, 0, 'h15};
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rv;
  logic er;
  int n;

  // ==========================================================================
  // clock, wire level of the aux pins, device
  initial begin
    forever #5 clk = ~clk;
  end
  // a driven pin shows its own drive, an undriven one the outside level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);

  leadoff_gpio_pace_breathing_control_regs #(.NUM_CHANNELS(6), .BREATH_DIV(DIV)) dut_u (
    .CLK(clk), .RESET_N(reset_n), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LEAD_OFF_POS_IN(lo_pos), .LEAD_OFF_NEG_IN(lo_neg), .TOP_RATE(top_rate), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .SENSE_POS_EN(sp), .SENSE_NEG_EN(sn), .CURRENT_DIR(cd),
    .TAP_ROUTE(tap_route), .BREATHING_MODE(br_mode));

  // ==========================================================================
  // reporting
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // ==========================================================================
  // apb master: request held until pready is seen, released after that edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    // ready is read as it stood at the rising edge, before that edge's updates land
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      $display("ERROR %0t apb answer never came", $time);
      stop_test();
    end
    rv = prdata;
    er = pslverr;
    req <= '0;
  endtask

  // model of a write: status words keep their value, pin data only moves on output pins
  task automatic wr(input int idx, input logic [7:0] v);
    logic [3:0] c, d;
    apb(1'b1, idx[5:0], {24'h0, v});
    chk(er, 0, "write error flag");
    c = m[5][3:0];
    d = m[5][7:4];
    case (idx)
      'h0F, 'h10, 'h11: m[idx - 15] = v & CH_MASK;
      'h14: m[5] = {(c & d) | (~c & v[7:4]), v[3:0]};
      'h15, 'h16: m[idx - 15] = v[4:0];
      default: ;
    endcase
  endtask

  task automatic rdchk(input int idx);
    logic [3:0] c, d;
    logic [7:0] e;
    // expectation taken after the transfer, so inputs changed just before the call have settled
    apb(1'b0, idx[5:0], 32'h0);
    c = m[5][3:0];
    d = m[5][7:4];
    case (idx)
      'h12: e = lo_pos;
      'h13: e = lo_neg;
      'h14: e = {(~c & d) | (c & ext_lvl), c};
      default: e = m[idx - 15][7:0];
    endcase
    chk(er, 0, "read error flag");
    chk(rv, {24'h0, e}, "read data");
  endtask

  // wait for a rising level on one pin drive bit, counting cycles
  task automatic wait_rise(input int b);
    logic p;
    p = pin_out[b];
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (p === 1'b0 && pin_out[b] === 1'b1) break;
      p = pin_out[b];
    end while (n < 200);
  endtask

  // ==========================================================================
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("ERROR %0t run took too long", $time);
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    static logic [7:0] seq[5] = '{8'h00, 8'hA0, 8'h5F, 8'hFF, 8'h30};
    logic [1:0] md;
    void'($urandom(61081));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 'h0F; i <= 'h16; i++) if (i != 'h14) rdchk(i);
    apb(1'b0, 6'h14, 32'h0);
    chk(rv[3:0], 4'hF, "pin directions after reset");
    chk(pin_oe_n, 4'b0011, "pin enables after reset");
    chk(br_mode, 2'b01, "mode after reset");
    $display("reset values done");
    for (int i = 'h0F; i <= 'h11; i++) begin
      repeat (4) begin
        wr(i, 8'($urandom()));
        rdchk(i);
        chk({sp, sn, cd}, {m[0][7:0], m[1][7:0], m[2][7:0]}, "sense outputs");
      end
    end
    $display("sense and direction done");
    repeat (3) begin
      @(posedge clk);
      lo_pos <= 8'($urandom()) & CH_MASK;
      lo_neg <= 8'($urandom()) & CH_MASK;
      // status is checked on every bit, unmasked by the sense enables; writes of FFh must leave it unchanged
      rdchk('h12);
      rdchk('h13);
      wr('h12, 8'hFF);
      wr('h13, 8'hFF);
      rdchk('h12);
      rdchk('h13);
    end
    $display("status done");
    for (int c = 0; c < 32; c++) begin
      wr('h15, c[7:0]);
      rdchk('h15);
      chk(tap_route, {4'h1 + {c[2:1], 1'b0}, 4'h2 + {c[4:3], 1'b0}, c[0]}, "tap route");
    end
    $display("tap routing done");
    wr('h16, 8'h14);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      ext_lvl <= 4'($urandom());
      wr('h14, (i < 5) ? seq[i] : 8'($urandom()));
      repeat (2) @(posedge clk);
      chk(pin_oe_n, m[5][3:0], "pin enables");
      chk(pin_out & ~m[5][3:0], m[5][7:4] & ~m[5][3:0], "pin drive");
      rdchk('h14);
    end
    $display("aux pins done");
    for (int i = 0; i < 4; i++) begin
      md = i[1:0];
      wr('h16, {3'h5, md});
      repeat (2) @(posedge clk);
      chk(br_mode, md, "mode output");
      chk(pin_oe_n, md[0] ? {3'b001, m[5][0]} : m[5][3:0], "pin ownership");
    end
    for (int p = 0; p < 9; p++) begin
      @(posedge clk);
      top_rate <= (p < 8);
      wr('h16, {p[2:0], 2'b01});
      wait_rise(2);
      wait_rise(2);
      wait_rise(3);
      chk(n, (p < 8) ? (p + 1) * DIV : 8 * DIV, "pin four lag");
    end
    $display("breathing done");
    apb(1'b0, 6'h17, 32'h0);
    chk(er, 1, "unmapped read error");
    chk(rv, 32'h0, "unmapped read");
    apb(1'b0, 6'h0E, 32'h0);
    chk(er, 1, "unmapped read low error");
    chk(rv, 32'h0, "unmapped read low");
    $display("unmapped done");
    stop_test();
  end
endmodule
